// file: common/abmi_params.svh
// Constants of the asynchronous bus micro-interface: fields, codes, timing
`ifndef ABMI_PARAMS_SVH
`define ABMI_PARAMS_SVH

// Microword, address and data widths; FIFO depth
`define ABMI_WORD_W        32
`define ABMI_ADDR_W        6
`define ABMI_DATA_W        16
`define ABMI_FIFO_DEPTH    32

// Sequencer opcodes
`define ABMI_OP_RET        5'h02
`define ABMI_OP_LDPL       5'h04
`define ABMI_OP_DEC        5'h09
`define ABMI_OP_CONT       5'h0d
`define ABMI_OP_CMP        5'h10
`define ABMI_OP_GOTO       5'h19
`define ABMI_OP_WAIT       5'h1a
`define ABMI_OP_CALL       5'h1c

// Test select codes
`define ABMI_T_MSYN        3'h0
`define ABMI_T_SSYN        3'h1
`define ABMI_T_BBSY        3'h2
`define ABMI_T_BG          3'h3
`define ABMI_T_NPG         3'h4
`define ABMI_T_AUX         3'h5
`define ABMI_T_PASS        3'h6
`define ABMI_T_EQ          3'h7

// Auxiliary select codes
`define ABMI_A_SLVREQ      3'h0
`define ABMI_A_DMAREQ      3'h1
`define ABMI_A_INTREQ      3'h2
`define ABMI_A_WRITE       3'h3
`define ABMI_A_C1          3'h4

// Command bit positions
`define ABMI_C_ADDR        11
`define ABMI_C_DATA        10
`define ABMI_C_CAP         9
`define ABMI_C_DONE        8
`define ABMI_C_C1          7
`define ABMI_C_INTR        6
`define ABMI_C_BR          5
`define ABMI_C_NPR         4
`define ABMI_C_SACK        3
`define ABMI_C_BBSY        2
`define ABMI_C_SSYN        1
`define ABMI_C_MSYN        0

// Addresses and loads
`define ABMI_RESET_ADDR    6'h3f
`define ABMI_TIMEOUT_LOAD  6'h31
`define ABMI_MASK_NPG_BB_SS 6'h16
`define ABMI_MASK_BG_BB_SS 6'h0e

// Timing
`define ABMI_CLK_PERIOD_PS 40000
`define ABMI_MIN_PERIOD_PS 64500
`define ABMI_TIMEOUT_NS    15000

`endif

// file: common/abmi_pkg.sv
// Types of the asynchronous bus micro-interface
package abmi_pkg;

	typedef struct packed {
		logic        oe;
		logic [4:0]  opcode;
		logic        pol;
		logic [2:0]  test;
		logic [5:0]  data;
		logic        err;
		logic [2:0]  aux;
		logic [11:0] cmd;
	} abmi_word_s;

	typedef logic [5:0] abmi_addr_t;

	typedef enum logic {
		ABMI_BOOT,
		ABMI_RUN
	} abmi_state_e;

endpackage : abmi_pkg

// file: common/abmi_stream_if.sv
// Valid/ready word stream between the block's own modules
`timescale 1ns/1ps
interface abmi_stream_if #(
	parameter int W = 16
);
	logic [W-1:0] data;
	logic         valid;
	logic         ready;

	modport src (output data, output valid, input ready);
	modport snk (input data, input valid, output ready);
endinterface : abmi_stream_if

// file: rtl/abmi_fifo.sv
// Synchronous FIFO between bus data capture and the peripheral
`timescale 1ns/1ps
module abmi_fifo #(
	parameter int W     = 16,
	parameter int DEPTH = 32
) (
	// Clock and reset
	input  wire logic clk_in,
	input  wire logic rst_b_in,
	// Streams
	abmi_stream_if.snk wr,
	abmi_stream_if.src rd
);
	localparam int AW = $clog2(DEPTH);

	logic [W-1:0] mem [DEPTH];
	logic [AW:0]  wp_q;
	logic [AW:0]  rp_q;
	logic         full;
	logic         empty;
	logic         push;
	logic         pop;

	assign full     = (wp_q[AW] != rp_q[AW]) && (wp_q[AW-1:0] == rp_q[AW-1:0]);
	assign empty    = (wp_q == rp_q);
	assign wr.ready = !full;
	assign rd.valid = !empty;
	assign rd.data  = mem[rp_q[AW-1:0]];
	assign push     = wr.valid && !full;
	assign pop      = rd.ready && !empty;

	always_ff @(posedge clk_in) begin
		if (push) begin
			mem[wp_q[AW-1:0]] <= wr.data;
		end
	end

	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			wp_q <= '0;
			rp_q <= '0;
		end else begin
			if (push) begin
				wp_q <= wp_q + 1'b1;
			end
			if (pop) begin
				rp_q <= rp_q + 1'b1;
			end
		end
	end
endmodule : abmi_fifo

// file: rtl/abmi_urom.sv
// Microprogram store of the bus controller
`timescale 1ns/1ps
`include "abmi_params.svh"
module abmi_urom (
	// Address and word
	input  wire logic              [5:0] addr_in,
	output abmi_pkg::abmi_word_s         word_out
);
	function automatic abmi_pkg::abmi_word_s mw(
		input logic [4:0]  op,
		input logic        pol,
		input logic [2:0]  tst,
		input logic [5:0]  dat,
		input logic        err,
		input logic [2:0]  aux,
		input logic [11:0] cmd
	);
		mw = {1'b1, op, pol, tst, dat, err, aux, cmd};
	endfunction : mw

	localparam logic [11:0] BR   = 12'h020;
	localparam logic [11:0] SACK = 12'h008;
	localparam logic [11:0] BBSY = 12'h004;
	localparam logic [11:0] SSYN = 12'h002;
	localparam logic [11:0] MSYN = 12'h001;
	localparam logic [11:0] ADDR = 12'h800;
	localparam logic [11:0] DOUT = 12'h400;
	localparam logic [11:0] DIN  = 12'h200;
	localparam logic [11:0] DONE = 12'h100;
	localparam logic [11:0] INTR = 12'h040;
	localparam logic [11:0] NPR  = 12'h010;
	localparam logic [11:0] OFF  = 12'h000;

	always_comb begin
		case (addr_in)
			// Poll for slave access, DMA and interrupt requests
			6'h00: word_out = mw(`ABMI_OP_CALL, 1'b0, `ABMI_T_AUX, 6'h08, 1'b0, `ABMI_A_SLVREQ, OFF);
			6'h01: word_out = mw(`ABMI_OP_GOTO, 1'b0, `ABMI_T_AUX, 6'h10, 1'b0, `ABMI_A_DMAREQ, OFF);
			6'h02: word_out = mw(`ABMI_OP_GOTO, 1'b1, `ABMI_T_AUX, 6'h00, 1'b0, `ABMI_A_INTREQ, OFF);
			// Interrupt request, grant and vector
			6'h03: word_out = mw(`ABMI_OP_WAIT, 1'b0, `ABMI_T_BG, 6'h00, 1'b0, 3'h0, BR);
			6'h04: word_out = mw(`ABMI_OP_CMP, 1'b0, `ABMI_T_PASS, `ABMI_MASK_BG_BB_SS, 1'b0, 3'h0, SACK);
			6'h05: word_out = mw(`ABMI_OP_GOTO, 1'b1, `ABMI_T_EQ, 6'h04, 1'b0, 3'h0, SACK);
			6'h06: word_out = mw(`ABMI_OP_WAIT, 1'b0, `ABMI_T_SSYN, 6'h00, 1'b0, 3'h0, BBSY|INTR|DOUT);
			6'h07: word_out = mw(`ABMI_OP_GOTO, 1'b0, `ABMI_T_PASS, 6'h00, 1'b0, 3'h0, DONE);
			// Slave access: c1 high is a write into the device
			6'h08: word_out = mw(`ABMI_OP_GOTO, 1'b0, `ABMI_T_AUX, 6'h0b, 1'b0, `ABMI_A_C1, OFF);
			6'h09: word_out = mw(`ABMI_OP_WAIT, 1'b1, `ABMI_T_MSYN, 6'h00, 1'b0, 3'h0, SSYN|DOUT);
			6'h0a: word_out = mw(`ABMI_OP_RET, 1'b0, `ABMI_T_PASS, 6'h00, 1'b0, 3'h0, OFF);
			6'h0b: word_out = mw(`ABMI_OP_CONT, 1'b0, `ABMI_T_PASS, 6'h00, 1'b0, 3'h0, DIN);
			6'h0c: word_out = mw(`ABMI_OP_WAIT, 1'b1, `ABMI_T_MSYN, 6'h00, 1'b0, 3'h0, SSYN);
			6'h0d: word_out = mw(`ABMI_OP_RET, 1'b0, `ABMI_T_PASS, 6'h00, 1'b0, 3'h0, OFF);
			// DMA request and bus acquisition
			6'h10: word_out = mw(`ABMI_OP_WAIT, 1'b1, `ABMI_T_NPG, 6'h00, 1'b0, 3'h0, OFF);
			6'h11: word_out = mw(`ABMI_OP_WAIT, 1'b0, `ABMI_T_NPG, 6'h00, 1'b0, 3'h0, NPR);
			6'h12: word_out = mw(`ABMI_OP_CMP, 1'b0, `ABMI_T_PASS, `ABMI_MASK_NPG_BB_SS, 1'b0, 3'h0, SACK);
			6'h13: word_out = mw(`ABMI_OP_GOTO, 1'b1, `ABMI_T_EQ, 6'h12, 1'b0, 3'h0, SACK);
			6'h14: word_out = mw(`ABMI_OP_GOTO, 1'b0, `ABMI_T_AUX, 6'h1c, 1'b0, `ABMI_A_WRITE, BBSY);
			// Master read with slave timeout
			6'h15: word_out = mw(`ABMI_OP_LDPL, 1'b0, `ABMI_T_PASS, `ABMI_TIMEOUT_LOAD, 1'b0, 3'h0, BBSY|ADDR);
			6'h16: word_out = mw(`ABMI_OP_GOTO, 1'b0, `ABMI_T_SSYN, 6'h19, 1'b0, 3'h0, BBSY|ADDR|MSYN);
			6'h17: word_out = mw(`ABMI_OP_DEC, 1'b0, `ABMI_T_PASS, 6'h16, 1'b0, 3'h0, BBSY|ADDR|MSYN);
			6'h18: word_out = mw(`ABMI_OP_GOTO, 1'b0, `ABMI_T_PASS, 6'h00, 1'b1, 3'h0, OFF);
			6'h19: word_out = mw(`ABMI_OP_CONT, 1'b0, `ABMI_T_PASS, 6'h00, 1'b0, 3'h0, BBSY|ADDR|MSYN|DIN);
			6'h1a: word_out = mw(`ABMI_OP_GOTO, 1'b0, `ABMI_T_PASS, 6'h00, 1'b0, 3'h0, DONE);
			// Master write with slave timeout
			6'h1c: word_out = mw(`ABMI_OP_LDPL, 1'b0, `ABMI_T_PASS, `ABMI_TIMEOUT_LOAD, 1'b0, 3'h0, BBSY|ADDR|DOUT);
			6'h1d: word_out = mw(`ABMI_OP_GOTO, 1'b0, `ABMI_T_SSYN, 6'h20, 1'b0, 3'h0, BBSY|ADDR|DOUT|MSYN);
			6'h1e: word_out = mw(`ABMI_OP_DEC, 1'b0, `ABMI_T_PASS, 6'h1d, 1'b0, 3'h0, BBSY|ADDR|DOUT|MSYN);
			6'h1f: word_out = mw(`ABMI_OP_GOTO, 1'b0, `ABMI_T_PASS, 6'h00, 1'b1, 3'h0, OFF);
			6'h20: word_out = mw(`ABMI_OP_GOTO, 1'b0, `ABMI_T_PASS, 6'h00, 1'b0, 3'h0, DONE);
			// Reset entry
			`ABMI_RESET_ADDR: word_out = mw(`ABMI_OP_GOTO, 1'b0, `ABMI_T_PASS, 6'h00, 1'b0, 3'h0, OFF);
			default: word_out = mw(`ABMI_OP_GOTO, 1'b0, `ABMI_T_PASS, 6'h00, 1'b0, 3'h0, OFF);
		endcase
	end
endmodule : abmi_urom

// file: rtl/abmi_ctrl.sv
// Microprogrammed controller bridging a peripheral to an asynchronous backplane bus
//
// What this block does
// RQ1: Each microword is 32 bits; upper half and aux bits 14 to 12 sequence, rest of lower half drives outputs.
// RQ2: Bit 31 enables output bits 15 to 8 synchronously.
// RQ3: Bits 30 to 26 hold the opcode chosen for this cycle.
// RQ4: Opcode 19 jumps, 1C calls to the data field address, 1A waits.
// RQ5: Bit 25 inverts the selected test when set.
// RQ6: Bits 24 to 22 pick msyn, ssyn, bbsy, bg, npg, aux, pass or equal.
// RQ7: Bits 21 to 16 give branch address, test mask or counter load.
// RQ8: Bit 15 flags a bus handshake timeout to the peripheral.
// RQ9: Bits 14 to 12 steer the aux mux, used only with test 5.
// RQ10: Aux codes: slave access, DMA, interrupt, write direction, c1; rest spare.
// RQ11: Bits 11 to 0 are twelve commands, address drive down to msyn.
// RQ12: Drive commands enable bus buffers; capture strobes bus data inward.
// RQ13: Completion tells the peripheral its interrupt or DMA cycle ended.
// RQ14: All ten test inputs are registered before any use.
// RQ15: Clock period at least 64.5 ns; the bench clocks at 40 ns.
// RQ16: One master and one slave per transfer; arbitrator grants mastership.
// RQ17: Transfer types word write, byte write, read, read-no-restore, by c0/c1; the block has no c0 and never sets its c1 command.
// RQ18: Interrupts use request levels 4 to 7, each with request and grant.
// RQ19: Grants are daisy chained by the bus, position sets priority.
// RQ20: Supports slave access, interrupts, DMA and master reads and writes.
// RQ21: Start at 63 after reset, jump to 0 and poll for requests.
// RQ22: Slave read holds ssyn and data until msyn drops, then returns quiet.
// RQ23: DMA: npg low, npr, npg, sack, all of npg bbsy ssyn low, bbsy.
// RQ24: Master loads counter with 31 hex; no ssyn before expiry takes error exit.
// RQ25: Fetched microword sits in a pipeline register updated every clock unless a full FIFO stalls capture.
`timescale 1ns/1ps
`include "abmi_params.svh"
module abmi_ctrl (
	// Clock and reset
	input  wire logic        clk_in,
	input  wire logic        rst_b_in,
	// Bus test inputs
	input  wire logic        msyn_in,
	input  wire logic        ssyn_in,
	input  wire logic        bbsy_in,
	input  wire logic        bg_in,
	input  wire logic        npg_in,
	input  wire logic        c1_in,
	// Peripheral request inputs
	input  wire logic        slave_req_in,
	input  wire logic        dma_req_in,
	input  wire logic        int_req_in,
	input  wire logic        dev_write_in,
	// Bus data and captured word stream to the peripheral
	input  wire logic [15:0] bus_data_in,
	output logic      [15:0] per_data_out,
	output logic             per_valid_out,
	input  wire logic        per_ready_in,
	// Peripheral command outputs
	output logic             timeout_err_out,
	output logic             addr_drive_en_out,
	output logic             data_drive_en_out,
	output logic             data_capture_strobe_out,
	output logic             complete_out,
	// Bus command outputs
	output logic             c1_out,
	output logic             intr_out,
	output logic             br_out,
	output logic             npr_out,
	output logic             sack_out,
	output logic             bbsy_out,
	output logic             ssyn_out,
	output logic             msyn_out,
	// Sequencer address, for observation
	output logic       [5:0] upc_out
);
	abmi_pkg::abmi_word_s  pw_q;
	abmi_pkg::abmi_word_s  pw_d;
	abmi_pkg::abmi_word_s  rom_word;
	abmi_pkg::abmi_state_e st_q;
	abmi_pkg::abmi_addr_t  pc_q;
	abmi_pkg::abmi_addr_t  pc_d;
	abmi_pkg::abmi_addr_t  ret_q;
	logic            [5:0] cnt_q;
	logic                  eq_q;
	logic            [9:0] tst_q;
	logic                  aux_sel;
	logic                  cond;
	logic                  stall;
	logic                  take;

	abmi_stream_if #(.W(`ABMI_DATA_W)) cap_s ();
	abmi_stream_if #(.W(`ABMI_DATA_W)) per_s ();

	function automatic abmi_pkg::abmi_addr_t inc(input abmi_pkg::abmi_addr_t a);
		inc = 6'(a + 6'h01);
	endfunction : inc

	// Test inputs: bit 0..4 direct, 5..9 through the aux mux
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			tst_q <= 10'h000;
		end else begin
			tst_q <= {c1_in, dev_write_in, int_req_in, dma_req_in, slave_req_in,
				npg_in, bg_in, bbsy_in, ssyn_in, msyn_in}; // see RQ14 RQ15
		end
	end

	// Aux mux; spare codes read low
	always_comb begin
		case (pw_q.aux)
			`ABMI_A_SLVREQ: aux_sel = tst_q[5]; // see RQ10
			`ABMI_A_DMAREQ: aux_sel = tst_q[6];
			`ABMI_A_INTREQ: aux_sel = tst_q[7];
			`ABMI_A_WRITE:  aux_sel = tst_q[8];
			`ABMI_A_C1:     aux_sel = tst_q[9]; // see RQ17
			default:        aux_sel = 1'b0;
		endcase
	end

	// Condition select and polarity
	always_comb begin
		case (pw_q.test)
			`ABMI_T_MSYN: cond = tst_q[0]; // see RQ6
			`ABMI_T_SSYN: cond = tst_q[1];
			`ABMI_T_BBSY: cond = tst_q[2];
			`ABMI_T_BG:   cond = tst_q[3];
			`ABMI_T_NPG:  cond = tst_q[4];
			`ABMI_T_AUX:  cond = aux_sel; // see RQ9
			`ABMI_T_PASS: cond = 1'b1;
			default:      cond = eq_q;
		endcase
		take = cond ^ pw_q.pol; // see RQ5
	end

	// Capture into the FIFO; a full FIFO freezes the sequencer so no word is lost
	assign cap_s.data  = bus_data_in;
	assign cap_s.valid = pw_q.oe && pw_q.cmd[`ABMI_C_CAP]; // see RQ12
	assign stall       = cap_s.valid && !cap_s.ready;

	abmi_fifo #(.W(`ABMI_DATA_W), .DEPTH(`ABMI_FIFO_DEPTH)) u_fifo (
		.clk_in   (clk_in),
		.rst_b_in (rst_b_in),
		.wr       (cap_s.snk),
		.rd       (per_s.src)
	);

	assign per_data_out  = per_s.data;
	assign per_valid_out = per_s.valid;
	assign per_s.ready   = per_ready_in;

	// Next address generation
	always_comb begin
		pc_d = inc(pc_q);
		if (st_q == abmi_pkg::ABMI_BOOT) begin
			pc_d = `ABMI_RESET_ADDR; // see RQ21
		end else if (stall) begin
			pc_d = pc_q;
		end else begin
			case (pw_q.opcode) // see RQ3
				`ABMI_OP_GOTO: begin
					if (take) begin
						pc_d = pw_q.data; // see RQ4
					end
				end
				`ABMI_OP_CALL: begin
					if (take) begin
						pc_d = pw_q.data; // see RQ4
					end
				end
				`ABMI_OP_WAIT: begin
					if (!take) begin
						pc_d = pc_q; // see RQ4
					end
				end
				`ABMI_OP_RET: begin
					if (take) begin
						pc_d = ret_q;
					end
				end
				`ABMI_OP_DEC: begin
					if (cnt_q != 6'h00) begin
						pc_d = pw_q.data; // see RQ24
					end
				end
				default: pc_d = inc(pc_q);
			endcase
		end
	end

	abmi_urom u_urom (
		.addr_in  (pc_d),
		.word_out (rom_word)
	);

	assign pw_d = stall ? pw_q : rom_word;

	// Boot state: first fetch is the reset entry word
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			st_q <= abmi_pkg::ABMI_BOOT;
		end else begin
			st_q <= abmi_pkg::ABMI_RUN;
		end
	end

	// Pipeline register and address, loaded every edge
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			pw_q <= '0;
			pc_q <= `ABMI_RESET_ADDR;
		end else begin
			pw_q <= pw_d; // see RQ25 RQ1
			pc_q <= pc_d;
		end
	end

	// Single-level return address
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			ret_q <= 6'h00;
		end else if (st_q == abmi_pkg::ABMI_RUN && !stall &&
				pw_q.opcode == `ABMI_OP_CALL && take) begin
			ret_q <= inc(pc_q);
		end
	end

	// Loop counter: load, then count down for the slave timeout
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			cnt_q <= 6'h00;
		end else if (st_q == abmi_pkg::ABMI_RUN && !stall) begin
			if (pw_q.opcode == `ABMI_OP_LDPL) begin
				cnt_q <= pw_q.data; // see RQ7
			end else if (pw_q.opcode == `ABMI_OP_DEC && cnt_q != 6'h00) begin
				cnt_q <= 6'(cnt_q - 6'h01); // see RQ24
			end
		end
	end

	// Equal flag: masked test inputs compared with zero
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			eq_q <= 1'b0;
		end else if (st_q == abmi_pkg::ABMI_RUN && !stall &&
				pw_q.opcode == `ABMI_OP_CMP) begin
			eq_q <= ((tst_q[4:0] & pw_q.data[4:0]) == 5'h00); // see RQ23
		end
	end

	// Outputs straight from the pipeline; bits 15..8 only under the enable
	assign timeout_err_out         = pw_q.oe && pw_q.err; // see RQ8
	assign addr_drive_en_out       = pw_q.oe && pw_q.cmd[`ABMI_C_ADDR]; // see RQ2
	assign data_drive_en_out       = pw_q.oe && pw_q.cmd[`ABMI_C_DATA]; // see RQ12
	assign data_capture_strobe_out = cap_s.valid;
	assign complete_out            = pw_q.oe && pw_q.cmd[`ABMI_C_DONE]; // see RQ13
	assign c1_out                  = pw_q.cmd[`ABMI_C_C1]; // see RQ11
	assign intr_out                = pw_q.cmd[`ABMI_C_INTR];
	assign br_out                  = pw_q.cmd[`ABMI_C_BR]; // see RQ18
	assign npr_out                 = pw_q.cmd[`ABMI_C_NPR];
	assign sack_out                = pw_q.cmd[`ABMI_C_SACK];
	assign bbsy_out                = pw_q.cmd[`ABMI_C_BBSY]; // see RQ16
	assign ssyn_out                = pw_q.cmd[`ABMI_C_SSYN]; // see RQ22
	assign msyn_out                = pw_q.cmd[`ABMI_C_MSYN]; // see RQ20
	assign upc_out                 = pc_q;
endmodule : abmi_ctrl

// file: verif/abmi_ctrl_properties.sv
// Concurrent checks on the bus controller ports
`timescale 1ns/1ps
module abmi_ctrl_properties (
	// Clock and reset
	input wire logic       clk_in,
	input wire logic       rst_b_in,
	// Inputs
	input wire logic       msyn_in,
	input wire logic       ssyn_in,
	input wire logic       bg_in,
	input wire logic       npg_in,
	input wire logic       per_ready_in,
	// Outputs
	input wire logic       per_valid_out,
	input wire logic       timeout_err_out,
	input wire logic       data_capture_strobe_out,
	input wire logic       complete_out,
	input wire logic       npr_out,
	input wire logic       sack_out,
	input wire logic       ssyn_out,
	input wire logic       msyn_out,
	input wire logic       addr_drive_en_out,
	input wire logic       bbsy_out,
	input wire logic [5:0] upc_out
);
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (!rst_b_in);

	// Saturates so a stuck strobe cannot wrap back under the limit
	logic [7:0] msyn_run_q;
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in)
			msyn_run_q <= 8'h00;
		else if (!msyn_out)
			msyn_run_q <= 8'h00;
		else if (msyn_run_q != 8'hff)
			msyn_run_q <= msyn_run_q + 8'h01;
	end

	sequence s_boot;
		upc_out == 6'h3f ##1 upc_out == 6'h3f ##1 upc_out == 6'h00;
	endsequence
	sequence s_late_error;
		msyn_run_q >= 8'h31 ##1 !timeout_err_out;
	endsequence

	property p_boot;
		$rose(rst_b_in) |-> s_boot;
	endproperty
	a_boot: assert property (p_boot) else $error("boot address order wrong");
	property p_slave_hold;
		ssyn_out && msyn_in |-> ##2 ssyn_out;
	endproperty
	a_slave_hold: assert property (p_slave_hold) else $error("ssyn dropped early");
	property p_slave_release;
		ssyn_out && !msyn_in |-> ##[1:3] !ssyn_out;
	endproperty
	a_slave_release: assert property (p_slave_release) else $error("ssyn held");
	property p_npr_order;
		$rose(npr_out) |-> !$past(npg_in, 2);
	endproperty
	a_npr_order: assert property (p_npr_order) else $error("npr before grant idle");
	property p_sack_grant;
		$rose(sack_out) |-> $past(npg_in, 2) || $past(bg_in, 2);
	endproperty
	a_sack_grant: assert property (p_sack_grant) else $error("sack without grant");
	property p_timeout;
		$rose(timeout_err_out) |-> s_late_error;
	endproperty
	a_timeout: assert property (p_timeout) else $error("timeout early or long");
	property p_complete;
		$rose(complete_out) |-> $past(ssyn_in, 2) || $past(ssyn_in, 3);
	endproperty
	a_complete: assert property (p_complete) else $error("complete without ssyn");
	property p_capture;
		data_capture_strobe_out && !per_ready_in |=> per_valid_out;
	endproperty
	a_capture: assert property (p_capture) else $error("captured word lost");
	property p_mdrive;
		msyn_out |-> addr_drive_en_out && bbsy_out;
	endproperty
	a_mdrive: assert property (p_mdrive) else $error("msyn unqualified");
endmodule : abmi_ctrl_properties

bind abmi_ctrl abmi_ctrl_properties u_props (.clk_in, .rst_b_in, .msyn_in, .ssyn_in, .bg_in,
	.npg_in, .per_ready_in, .per_valid_out, .timeout_err_out, .data_capture_strobe_out,
	.complete_out, .npr_out, .sack_out, .ssyn_out, .msyn_out, .upc_out, .addr_drive_en_out,
	.bbsy_out);

// file: verif/abmi_bus_model.sv
// Far side of the bus: master, slave and arbitrator
`timescale 1ns/1ps
module abmi_bus_model (
	// Clock and reset
	input  wire logic        clk_in,
	input  wire logic        rst_b_in,
	// Scenario control
	input  wire logic        go_in,
	input  wire logic        go_wr_in,
	input  wire logic [15:0] go_data_in,
	input  wire logic [15:0] rd_data_in,
	input  wire logic [7:0]  dly_in,
	input  wire logic        mute_in,
	// Controller commands
	input  wire logic        msyn_cmd_in,
	input  wire logic        ssyn_cmd_in,
	input  wire logic        npr_cmd_in,
	input  wire logic        br_cmd_in,
	input  wire logic        sack_cmd_in,
	input  wire logic        intr_cmd_in,
	// Bus lines
	output logic             msyn_out,
	output logic             ssyn_out,
	output logic             bbsy_out,
	output logic             bg_out,
	output logic             npg_out,
	output logic             c1_out,
	output logic             slave_req_out,
	output logic      [15:0] bus_data_out,
	output logic             done_out
);
	logic [7:0]  wait_q;
	logic [15:0] data_q;
	logic [15:0] pat_q;
	logic        busy_q;

	// Single requester, so the daisy chain collapses to one grant
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			npg_out <= 1'b0;
			bg_out <= 1'b0;
		end else begin
			npg_out <= npr_cmd_in & ~sack_cmd_in;
			bg_out <= br_cmd_in & ~sack_cmd_in;
		end
	end

	// Addressed slave or vector reader; may answer late or never
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			ssyn_out <= 1'b0;
			wait_q <= 8'h00;
		end else if (!msyn_cmd_in && !intr_cmd_in) begin
			ssyn_out <= 1'b0;
			wait_q <= 8'h00;
		end else if (mute_in)
			ssyn_out <= 1'b0;
		else if (wait_q == dly_in)
			ssyn_out <= 1'b1;
		else
			wait_q <= wait_q + 8'h01;
	end

	// Master addressing the controller; holds msyn until the slave answers
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			{busy_q, msyn_out, bbsy_out, c1_out, slave_req_out, done_out} <= 6'h00;
			data_q <= 16'h0000;
			pat_q <= 16'h0000;
		end else begin
			done_out <= 1'b0;
			pat_q <= pat_q + 16'h3c5b;
			if (go_in) begin
				{busy_q, msyn_out, bbsy_out, slave_req_out} <= 4'hf;
				c1_out <= go_wr_in;
				data_q <= go_data_in;
			end else if (busy_q && msyn_out && ssyn_cmd_in)
				{msyn_out, slave_req_out} <= 2'h0;
			else if (busy_q && !msyn_out && !ssyn_cmd_in) begin
				{busy_q, bbsy_out, c1_out} <= 3'h0;
				done_out <= 1'b1;
			end
		end
	end

	// Released lines change every cycle so a stale sample cannot match
	assign bus_data_out = (msyn_out && c1_out) ? data_q : (ssyn_out ? rd_data_in : pat_q);
endmodule : abmi_bus_model

// file: verif/test_abmi_ctrl.sv
// Self-checking bench of the bus controller
`timescale 1ns/1ps
module test_abmi_ctrl;
	typedef struct packed {
		logic [1:0]  kind;
		logic        wr;
		logic [7:0]  dly;
		logic        mute;
		logic [15:0] dat;
		logic [3:0]  exp;
	} abmi_row_s;

	// Kind 0 slave, 1 DMA, 2 interrupt; exp: complete, timeout, word queued, data drive
	localparam abmi_row_s rows [8] = '{
		'{2'h0, 1'h0, 8'h00, 1'h0, 16'h0000, 4'h1},
		'{2'h0, 1'h1, 8'h00, 1'h0, 16'ha5c3, 4'h2},
		'{2'h1, 1'h0, 8'h00, 1'h0, 16'h1234, 4'ha},
		'{2'h1, 1'h0, 8'h14, 1'h0, 16'hbeef, 4'ha},
		'{2'h1, 1'h1, 8'h03, 1'h0, 16'h5a5a, 4'h9},
		'{2'h1, 1'h0, 8'h00, 1'h1, 16'h0f0f, 4'h4},
		'{2'h1, 1'h1, 8'h00, 1'h1, 16'h0f0f, 4'h5},
		'{2'h2, 1'h0, 8'h00, 1'h0, 16'h0000, 4'h9}};

	logic        clk_in = 1'b0;
	logic        rst_b_in = 1'b0;
	logic        dma_req_in = 1'b0;
	logic        int_req_in = 1'b0;
	logic        dev_write_in = 1'b0;
	logic        per_ready_in = 1'b0;
	logic        go_in = 1'b0;
	logic        go_wr_in = 1'b0;
	logic        mute_in = 1'b0;
	logic [7:0]  dly_in = 8'h00;
	logic [15:0] go_data_in = 16'h0000;
	logic [15:0] rd_data_in = 16'h0000;
	logic [3:0]  seen = 4'h0;
	int          err_total = 0;
	int          compares = 0;
	wire logic        msyn_in, ssyn_in, bbsy_in, bg_in, npg_in, c1_in, slave_req_in, done;
	wire logic [15:0] bus_data_in, per_data_out;
	wire logic        per_valid_out, timeout_err_out, addr_drive_en_out, data_drive_en_out;
	wire logic        data_capture_strobe_out, complete_out, c1_out, intr_out, br_out, npr_out;
	wire logic        sack_out, bbsy_out, ssyn_out, msyn_out;
	wire logic [5:0]  upc_out;

	abmi_ctrl dut (.clk_in, .rst_b_in, .msyn_in, .ssyn_in, .bbsy_in, .bg_in, .npg_in, .c1_in,
		.slave_req_in, .dma_req_in, .int_req_in, .dev_write_in, .bus_data_in, .per_data_out,
		.per_valid_out, .per_ready_in, .timeout_err_out, .addr_drive_en_out, .data_drive_en_out,
		.data_capture_strobe_out, .complete_out, .c1_out, .intr_out, .br_out, .npr_out,
		.sack_out, .bbsy_out, .ssyn_out, .msyn_out, .upc_out);
	abmi_bus_model far (.clk_in, .rst_b_in, .go_in, .go_wr_in, .go_data_in, .rd_data_in,
		.dly_in, .mute_in, .msyn_cmd_in(msyn_out), .ssyn_cmd_in(ssyn_out), .npr_cmd_in(npr_out),
		.br_cmd_in(br_out), .sack_cmd_in(sack_out), .intr_cmd_in(intr_out), .msyn_out(msyn_in),
		.ssyn_out(ssyn_in), .bbsy_out(bbsy_in), .bg_out(bg_in), .npg_out(npg_in), .c1_out(c1_in),
		.slave_req_out(slave_req_in), .bus_data_out(bus_data_in), .done_out(done));

	always #20 clk_in = ~clk_in;

	always @(posedge clk_in)
		seen <= seen | {complete_out, timeout_err_out, addr_drive_en_out, data_drive_en_out};

	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		compares++;
		if (got !== exp) begin
			err_total++;
			$display("FAIL %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task automatic report_and_stop;
		if (err_total == 0 && compares > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : report_and_stop

	// Called at a rising edge; releases reset and follows the boot fetch
	task automatic boot_chk;
		rst_b_in <= 1'b1;
		repeat (2) @(negedge clk_in);
		chk("boot address", 16'h003f, {10'h000, upc_out});
		@(negedge clk_in);
		chk("poll address", 16'h0000, {10'h000, upc_out});
	endtask : boot_chk

	task automatic pop(input logic [15:0] exp);
		@(negedge clk_in);
		chk("head word", exp, per_data_out);
		@(posedge clk_in);
		per_ready_in <= 1'b1;
		@(posedge clk_in);
		per_ready_in <= 1'b0;
	endtask : pop

	// Requests drop once the controller has taken them, so the poll does not rerun them
	task automatic run(input abmi_row_s r);
		int n;
		@(negedge clk_in);
		seen = 4'h0;
		@(posedge clk_in);
		{go_wr_in, dev_write_in, dly_in, mute_in} <= {r.wr, r.wr, r.dly, r.mute};
		go_data_in <= r.dat;
		rd_data_in <= r.dat;
		go_in <= (r.kind == 2'h0);
		dma_req_in <= (r.kind == 2'h1);
		int_req_in <= (r.kind == 2'h2);
		n = 0;
		do begin
			@(posedge clk_in);
			go_in <= 1'b0;
			if (npr_out)
				dma_req_in <= 1'b0;
			if (br_out)
				int_req_in <= 1'b0;
			n++;
		end while (n < 400 && !done && !complete_out && !timeout_err_out);
		repeat (8) @(posedge clk_in);
		chk("transfer end", 16'h0001, {15'h0000, n < 400});
		chk("transfer flags", {12'h000, r.exp & 4'hd}, {12'h000, seen & 4'hd});
		chk("addr drive", {15'h0000, r.kind == 2'h1}, {15'h0000, seen[1]});
	endtask : run

	// Whole sequence needs under 2000 cycles; ten times that is a hang
	initial begin
		repeat (20000) @(posedge clk_in);
		err_total++;
		report_and_stop();
	end

	initial begin
		repeat (2) @(posedge clk_in);
		boot_chk();
		foreach (rows[i]) begin
			run(rows[i]);
			@(negedge clk_in);
			chk("queued flag", {15'h0000, rows[i].exp[1]}, {15'h0000, per_valid_out});
			if (rows[i].exp[1])
				pop(rows[i].dat);
		end
		for (int i = 0; i < 32; i++)
			run('{2'h0, 1'h1, 8'h00, 1'h0, 16'h0100 + 16'(i), 4'h2});
		@(posedge clk_in);
		go_data_in <= 16'h0120;
		go_in <= 1'b1;
		@(posedge clk_in);
		go_in <= 1'b0;
		repeat (30) @(posedge clk_in);
		@(negedge clk_in);
		chk("full stall", 16'h0001, {15'h0000, data_capture_strobe_out & ~ssyn_out});
		for (int i = 0; i < 33; i++)
			pop(16'h0100 + 16'(i));
		@(negedge clk_in);
		chk("drained", 16'h0000, {15'h0000, per_valid_out});
		@(posedge clk_in);
		{mute_in, dev_write_in, dma_req_in} <= 3'h5;
		repeat (40) @(posedge clk_in);
		rst_b_in <= 1'b0;
		dma_req_in <= 1'b0;
		@(negedge clk_in);
		chk("reset state", 16'h003f, {npr_out, msyn_out, bbsy_out, sack_out, per_valid_out,
			timeout_err_out, c1_out, addr_drive_en_out, intr_out, br_out,
			upc_out});
		@(posedge clk_in);
		boot_chk();
		report_and_stop();
	end
endmodule : test_abmi_ctrl
